// file: hw/aalo_pkg.sv
// Package of opcodes, flag positions and carrier types for the add and logic datapath
package aalo_pkg;
	localparam int DATA_W = 8;
	localparam int HALF_W = 4;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ACC_RESET = 8'h00;
	// Status flag bit positions
	localparam int FLAG_WRAP = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_NULL = 2;
	localparam int FLAG_SIGNED_WRAP = 3;
	localparam int FLAG_SIGNED_REL = 4;
	localparam int FLAG_W = 5;
	localparam logic [4:0] FLAGS_RESET = 5'h00;

	typedef enum logic [2:0] {
		AALO_OP_NONE,
		AALO_OP_ADD_TO_MEMORY,
		AALO_OP_AND_MEMORY_TO_WORK,
		AALO_OP_AND_IMMEDIATE,
		AALO_OP_AND_INTO_MEMORY
	} aalo_op_type;

	typedef struct packed {
		aalo_op_type op;
		logic [7:0] mem_data;
		logic [7:0] imm_data;
	} aalo_req_type;

	typedef struct packed {
		logic [7:0] sum;
		logic wrap_out;
		logic half_wrap;
		logic signed_wrap;
		logic signed_rel;
	} aalo_add_type;
endpackage : aalo_pkg

// file: hw/aalo_adder.sv
// Eight-bit adder producing sum and arithmetic flags
`timescale 1ns/1ps
`default_nettype none
module aalo_adder
(
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	output wire aalo_pkg::aalo_add_type res_o
);
	wire logic [4:0] low_sum;
	wire logic [8:0] full_sum;
	wire logic sign_ovf;

	assign low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
	assign full_sum = {1'b0, a_i} + {1'b0, b_i};
	// Overflow when both operands share a sign the sum lacks
	assign sign_ovf = (a_i[7] == b_i[7]) && (full_sum[7] != a_i[7]);
	assign res_o.sum = full_sum[7:0];
	assign res_o.wrap_out = full_sum[8];
	assign res_o.half_wrap = low_sum[4];
	assign res_o.signed_wrap = sign_ovf;
	// True signed sign of the result, immune to overflow
	assign res_o.signed_rel = full_sum[7] ^ sign_ovf;
endmodule : aalo_adder
`default_nettype wire

// file: hw/aalo_core.sv
// Datapath for add-to-memory and the three AND operations
// What this block does
// - Add to memory writes sum, five flags
// - AND memory into working register, zero only
// - AND immediate into working register, zero only
// - AND into memory, bitwise per position
`timescale 1ns/1ps
`default_nettype none
module aalo_core
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic REQ_VALID_I,
	input wire aalo_pkg::aalo_req_type REQ_I,
	output logic [7:0] WORK_REG_O,
	output logic [7:0] MEM_WDATA_O,
	output logic MEM_WE_O,
	output logic [4:0] FLAGS_O
);
	////////////////////////////////////////////////////////////////
	logic [7:0] work_q;
	logic [7:0] work_d;
	logic [7:0] wdata_q;
	logic [7:0] wdata_d;
	logic we_q;
	logic we_d;
	logic [4:0] flags_q;
	logic [4:0] flags_d;
	aalo_pkg::aalo_add_type add_res;
	wire logic [7:0] and_mem;
	wire logic [7:0] and_imm;
	wire logic is_add;
	wire logic is_and_mem;
	wire logic is_and_imm;
	wire logic is_and_into;

	aalo_adder u_adder
	(
		.a_i(work_q),
		.b_i(REQ_I.mem_data),
		.res_o(add_res)
	);

	assign is_add = REQ_VALID_I && (REQ_I.op == aalo_pkg::AALO_OP_ADD_TO_MEMORY);
	assign is_and_mem = REQ_VALID_I && (REQ_I.op == aalo_pkg::AALO_OP_AND_MEMORY_TO_WORK);
	assign is_and_imm = REQ_VALID_I && (REQ_I.op == aalo_pkg::AALO_OP_AND_IMMEDIATE);
	assign is_and_into = REQ_VALID_I && (REQ_I.op == aalo_pkg::AALO_OP_AND_INTO_MEMORY);

	genvar gi;
	generate
		for (gi = 0; gi < aalo_pkg::DATA_W; gi++)
		begin : g_and
			assign and_mem[gi] = work_q[gi] & REQ_I.mem_data[gi];
			assign and_imm[gi] = work_q[gi] & REQ_I.imm_data[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		work_d = work_q;
		wdata_d = wdata_q;
		we_d = 1'b0;
		flags_d = flags_q;
		if (is_add)
		begin
			wdata_d = add_res.sum;
			we_d = 1'b1;
			flags_d[aalo_pkg::FLAG_WRAP] = add_res.wrap_out;
			flags_d[aalo_pkg::FLAG_HALF] = add_res.half_wrap;
			flags_d[aalo_pkg::FLAG_SIGNED_WRAP] = add_res.signed_wrap;
			flags_d[aalo_pkg::FLAG_SIGNED_REL] = add_res.signed_rel;
			flags_d[aalo_pkg::FLAG_NULL] = (add_res.sum == aalo_pkg::ZERO_BYTE);
		end
		else if (is_and_mem)
		begin
			work_d = and_mem;
			flags_d[aalo_pkg::FLAG_NULL] = (and_mem == aalo_pkg::ZERO_BYTE);
		end
		else if (is_and_imm)
		begin
			work_d = and_imm;
			flags_d[aalo_pkg::FLAG_NULL] = (and_imm == aalo_pkg::ZERO_BYTE);
		end
		else if (is_and_into)
		begin
			wdata_d = and_mem;
			we_d = 1'b1;
			// Flag effect is undocumented; zero flag updated like the other ANDs
			flags_d[aalo_pkg::FLAG_NULL] = (and_mem == aalo_pkg::ZERO_BYTE);
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge CLOCK_I)
	begin
		if (SYS_RST_I)
		begin
			work_q <= aalo_pkg::ACC_RESET;
			wdata_q <= aalo_pkg::ZERO_BYTE;
			we_q <= 1'b0;
			flags_q <= aalo_pkg::FLAGS_RESET;
		end
		else
		begin
			work_q <= work_d;
			wdata_q <= wdata_d;
			we_q <= we_d;
			flags_q <= flags_d;
		end
	end

	assign WORK_REG_O = work_q;
	assign MEM_WDATA_O = wdata_q;
	assign MEM_WE_O = we_q;
	assign FLAGS_O = flags_q;
endmodule : aalo_core
`default_nettype wire

// file: testbench/aalo_core_assertions.sv
// Port checker for the add and logic datapath
`timescale 1ns/1ps
`default_nettype none
module aalo_core_checker
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic REQ_VALID_I,
	input wire aalo_pkg::aalo_req_type REQ_I,
	input wire logic [7:0] WORK_REG_O,
	input wire logic [7:0] MEM_WDATA_O,
	input wire logic MEM_WE_O,
	input wire logic [4:0] FLAGS_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);
	wire logic ad = REQ_VALID_I && REQ_I.op == aalo_pkg::AALO_OP_ADD_TO_MEMORY;
	wire logic am = REQ_VALID_I && REQ_I.op == aalo_pkg::AALO_OP_AND_MEMORY_TO_WORK;
	wire logic ai = REQ_VALID_I && REQ_I.op == aalo_pkg::AALO_OP_AND_IMMEDIATE;
	wire logic an = REQ_VALID_I && REQ_I.op == aalo_pkg::AALO_OP_AND_INTO_MEMORY;
	////////////////////////////////////////////////////////////////
	a_add_sum: assert property (ad |=> MEM_WE_O &&
		{FLAGS_O[0], MEM_WDATA_O} == $past({1'b0, WORK_REG_O} + REQ_I.mem_data))
		else $error("add sum wrong");
	a_and_work: assert property (am |=> WORK_REG_O == $past(WORK_REG_O & REQ_I.mem_data)
		&& (FLAGS_O & 5'h1b) == ($past(FLAGS_O) & 5'h1b)) else $error("and memory wrong");
	a_and_imm: assert property (ai |=> WORK_REG_O == $past(WORK_REG_O & REQ_I.imm_data)
		&& (FLAGS_O & 5'h1b) == ($past(FLAGS_O) & 5'h1b)) else $error("and immediate wrong");
	a_and_into: assert property (an |=> MEM_WE_O &&
		MEM_WDATA_O == $past(WORK_REG_O & REQ_I.mem_data)) else $error("and into memory wrong");
	a_null_flag: assert property (am || ai |=> FLAGS_O[2] == (WORK_REG_O == 8'h00))
		else $error("null flag wrong");
	a_add_null: assert property (ad |=> FLAGS_O[2] == (MEM_WDATA_O == 8'h00))
		else $error("add null flag wrong");
	a_add_half: assert property (ad |=> FLAGS_O[1] ==
		$past({1'b0, WORK_REG_O[3:0]} + {1'b0, REQ_I.mem_data[3:0]} > 5'h0f))
		else $error("add half wrap flag wrong");
	a_idle_quiet: assert property (!(ad || am || ai || an) |=> !MEM_WE_O
		&& $stable(WORK_REG_O) && $stable(FLAGS_O)) else $error("idle cycle changed state");
endmodule : aalo_core_checker
bind aalo_core aalo_core_checker u_chk (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
	.REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .WORK_REG_O(WORK_REG_O),
	.MEM_WDATA_O(MEM_WDATA_O), .MEM_WE_O(MEM_WE_O), .FLAGS_O(FLAGS_O));
`default_nettype wire

// file: testbench/add_and_logic_ops_tb_top.sv
// Random bench with a reference model for the add and logic datapath
`timescale 1ns/1ps
`default_nettype none
module add_and_logic_ops_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic vld = 1'b0;
	aalo_pkg::aalo_req_type req = '0;
	logic [7:0] wrk, wd, acc, ewd;
	logic [4:0] fl, ef;
	logic we, ewe;
	logic [8:0] s;
	int num_errors = 0;
	int cmp_count = 0;
	int seed = 35;
	aalo_core dut (.CLOCK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(vld), .REQ_I(req),
		.WORK_REG_O(wrk), .MEM_WDATA_O(wd), .MEM_WE_O(we), .FLAGS_O(fl));
	////////////////////////////////////////////////////////////////
	task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task automatic results;
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	initial
	begin
		forever #50 clk = ~clk;
	end
	initial
	begin
		repeat (10) @(negedge clk);
		// Reset mid-run too, so recovery is exercised
		for (int i = 0; i < 600; i++)
		begin
			rst = (i == 0 || i == 300);
			vld = 1'($random(seed));
			req.op = aalo_pkg::aalo_op_type'(3'(($random(seed) & 7) % 5));
			req.mem_data = 8'($random(seed));
			req.imm_data = 8'($random(seed));
			ewe = 1'b0;
			if (rst)
			begin
				acc = 8'h00;
				ewd = 8'h00;
				ef = 5'h00;
			end
			else if (vld && req.op == aalo_pkg::AALO_OP_ADD_TO_MEMORY)
			begin
				s = {1'b0, acc} + {1'b0, req.mem_data};
				ewd = s[7:0];
				ewe = 1'b1;
				ef[3] = acc[7] == req.mem_data[7] && s[7] != acc[7];
				ef = {s[7] ^ ef[3], ef[3], s[7:0] == 8'h00,
					({1'b0, acc[3:0]} + {1'b0, req.mem_data[3:0]}) > 5'h0f, s[8]};
			end
			else if (vld && req.op == aalo_pkg::AALO_OP_AND_INTO_MEMORY)
			begin
				ewd = acc & req.mem_data;
				ewe = 1'b1;
				ef[2] = ewd == 8'h00;
			end
			else if (vld && req.op != aalo_pkg::AALO_OP_NONE)
			begin
				acc = acc & (req.op == aalo_pkg::AALO_OP_AND_IMMEDIATE ? req.imm_data : req.mem_data);
				ef[2] = acc == 8'h00;
			end
			@(negedge clk);
			cmp("work", acc, wrk);
			cmp("wdata", ewd, wd);
			cmp("we", {7'h00, ewe}, {7'h00, we});
			cmp("flags", {3'h0, ef}, {3'h0, fl});
		end
		results();
	end
endmodule : add_and_logic_ops_tb_top
`default_nettype wire
